// file: rtl/cwt_top.sv
/*
 calendar window timer: two timers behind an AXI4-Lite register slave,
 fed by a second-resolution calendar source.
 assumes calendar inputs and drive reset are synchronous to sys_clk and
 dt_tick pulses for one cycle as each new second is presented.
*/
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "cwt_consts.svh"

// Behaviour
// - timer runs regardless of destination routing
// - comparison granularity is one second
// - active from start until stop, else inactive
// - repeat code selects period, zero none
// - each period compares only its fields
// - week mode date means weekday, zero Sunday
// - stop at or before start: never active
// - disabled or code zero: raw output zero
// - invert complements final output after window
// - source change plus reset zeroes repeat, log
// - two identical timers with own settings
module cwt_top
   import cwt_pkg::*;
#(
   parameter int ADDR_W = `CWT_ADDR_W,
   parameter int N_TMR  = 2
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              dt_tick,
   input  wire logic [5:0]        dt_sec,
   input  wire logic [5:0]        dt_min,
   input  wire logic [4:0]        dt_hour,
   input  wire logic [4:0]        dt_day,
   input  wire logic [3:0]        dt_month,
   input  wire logic [6:0]        dt_year,
   input  wire logic [2:0]        dt_wday,
   input  wire logic              drv_reset,
   output logic [N_TMR-1:0]       tmr_out,
   output logic                   trip_log_clr
);
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;
   logic              aw_have_r;
   logic              w_have_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              do_wr;
   logic              wr_hit;
   logic [31:0]       cfg_r [N_TMR][6];
   logic              src_sel_r;
   logic              src_applied_r;
   logic              src_clr;
   logic              trip_clr_r;
   logic [N_TMR-1:0]  out_r;
   logic [N_TMR-1:0]  run;
   logic [N_TMR-1:0]  inv;
   logic [N_TMR-1:0]  win;
   cwt_dt_t           now;

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign tmr_out       = out_r;
   assign trip_log_clr  = trip_clr_r;

   assign now     = '{yr: dt_year, mo: dt_month, dy: dt_day, wd: dt_wday,
                      hr: dt_hour, mi: dt_min, se: dt_sec};
   assign do_wr   = aw_have_r && w_have_r && !bvalid_r;
   assign src_clr = drv_reset && (src_sel_r != src_applied_r);

   function automatic logic [31:0] wmask(input logic [2:0] idx);
      unique case (idx)
         `CWT_OFS_START_DT, `CWT_OFS_STOP_DT: wmask = `CWT_MASK_DATE;
         `CWT_OFS_START_TM, `CWT_OFS_STOP_TM: wmask = `CWT_MASK_TIME;
         `CWT_OFS_CTRL:                       wmask = `CWT_MASK_CTRL;
         default:                             wmask = `CWT_MASK_DEST;
      endcase
   endfunction

   function automatic logic [31:0] bytes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic cfg_addr(input logic [ADDR_W-1:0] a);
      return (a[ADDR_W-1:6] == '0) && (a[4:2] <= `CWT_OFS_DEST) && (32'(a[5]) < N_TMR);
   endfunction

   function automatic cwt_dt_t to_dt(input logic [31:0] d, input logic [31:0] tm);
      cwt_dt_t v;
      v.dy = d[`CWT_DT_DAY_LSB +: 5];
      v.mo = d[`CWT_DT_MON_LSB +: 4];
      v.yr = d[`CWT_DT_YR_LSB +: 7];
      // weekday is entered in the low year digits in week mode
      v.wd = d[`CWT_DT_YR_LSB +: 3];
      v.hr = tm[`CWT_TM_HR_LSB +: 5];
      v.mi = tm[`CWT_TM_MIN_LSB +: 6];
      v.se = tm[`CWT_TM_SEC_LSB +: 6];
      return v;
   endfunction

   assign wr_hit = cfg_addr(waddr_r) || (waddr_r == `CWT_ADDR_SRC_SEL);

   // write address channel
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_r <= 1'b1;
         aw_have_r <= 1'b0;
         waddr_r   <= '0;
      end
      else if (s_axi_awvalid && awready_r)
      begin
         awready_r <= 1'b0;
         aw_have_r <= 1'b1;
         waddr_r   <= s_axi_awaddr;
      end
      else if (do_wr)
         aw_have_r <= 1'b0;
      else if (bvalid_r && s_axi_bready)
         awready_r <= 1'b1;
   end

   // write data channel
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wready_r <= 1'b1;
         w_have_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end
      else if (s_axi_wvalid && wready_r)
      begin
         wready_r <= 1'b0;
         w_have_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end
      else if (do_wr)
         w_have_r <= 1'b0;
      else if (bvalid_r && s_axi_bready)
         wready_r <= 1'b1;
   end

   // write response
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= `CWT_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? `CWT_RESP_OKAY : `CWT_RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // timer settings; a source change outranks a same-cycle write
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int t = 0; t < N_TMR; t++)
            for (int i = 0; i < 6; i++)
               cfg_r[t][i] <= `CWT_CFG_RESET;
      end
      else
      begin
         if (do_wr && cfg_addr(waddr_r))
            cfg_r[waddr_r[5]][waddr_r[4:2]] <= (cfg_r[waddr_r[5]][waddr_r[4:2]] & ~bytes(wstrb_r))
                                              | (wdata_r & bytes(wstrb_r) & wmask(waddr_r[4:2]));
         if (src_clr)
            for (int t = 0; t < N_TMR; t++)
               cfg_r[t][`CWT_OFS_CTRL][`CWT_CTRL_REP_LSB +: 3] <= 3'h0;
      end
   end

   // date/time source selector, takes effect on the next drive reset
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_sel_r     <= 1'b0;
         src_applied_r <= 1'b0;
         trip_clr_r    <= 1'b0;
      end
      else
      begin
         if (do_wr && waddr_r == `CWT_ADDR_SRC_SEL && wstrb_r[0])
            src_sel_r <= wdata_r[0];
         if (drv_reset)
            src_applied_r <= src_sel_r;
         trip_clr_r <= src_clr;
      end
   end

   // read channel
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `CWT_RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= `CWT_RESP_OKAY;
         rdata_r   <= '0;
         if (cfg_addr(s_axi_araddr))
            rdata_r <= cfg_r[s_axi_araddr[5]][s_axi_araddr[4:2]];
         else if (s_axi_araddr[ADDR_W-1:6] == '0 && s_axi_araddr[4:2] == `CWT_OFS_STATUS
                  && 32'(s_axi_araddr[5]) < N_TMR)
            rdata_r <= {31'h0000_0000, out_r[s_axi_araddr[5]]};
         else if (s_axi_araddr == `CWT_ADDR_SRC_SEL)
            rdata_r <= {30'h0000_0000, src_applied_r, src_sel_r};
         else
            rresp_r <= `CWT_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // both timers share one calendar but keep their own settings
   for (genvar g = 0; g < N_TMR; g++)
   begin : g_tmr
      cwt_tmr_if tif ();
      assign tif.tick  = dt_tick;
      assign tif.now   = now;
      assign tif.start = to_dt(cfg_r[g][`CWT_OFS_START_DT], cfg_r[g][`CWT_OFS_START_TM]);
      assign tif.stop  = to_dt(cfg_r[g][`CWT_OFS_STOP_DT], cfg_r[g][`CWT_OFS_STOP_TM]);
      assign tif.rep   = cwt_rep_t'(cfg_r[g][`CWT_OFS_CTRL][`CWT_CTRL_REP_LSB +: 3]);
      assign win[g]    = tif.win;
      // destination setting is stored only; it never gates the timer
      assign run[g]    = cfg_r[g][`CWT_OFS_CTRL][`CWT_CTRL_EN_BIT] && (tif.rep != REP_NONE);
      assign inv[g]    = cfg_r[g][`CWT_OFS_CTRL][`CWT_CTRL_INV_BIT];

      cwt_timer u_tmr (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .t       (tif.core)
      );

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
         if (!rst_n)
            out_r[g] <= 1'b0;
         else
            out_r[g] <= (run[g] && win[g]) ^ inv[g];
      end
   end

   sequence s_src_change;
      drv_reset && (src_sel_r != src_applied_r);
   endsequence

   sequence s_cleared;
      // a second change right behind the first keeps the pulse up one more cycle
      (cfg_r[0][`CWT_OFS_CTRL][2:0] == 3'h0) && trip_clr_r ##1 (!trip_clr_r || $past(src_clr));
   endsequence

   property p_src_clear;
      @(posedge sys_clk) disable iff (!rst_n) s_src_change |=> s_cleared;
   endproperty
   a_src_clear: assert property (p_src_clear) else $error("source change did not clear timers");

   property p_off_low;
      @(posedge sys_clk) disable iff (!rst_n) !run[0] && !inv[0] |=> !out_r[0];
   endproperty
   a_off_low: assert property (p_off_low) else $error("disabled timer output not low");

   property p_off_inverted;
      @(posedge sys_clk) disable iff (!rst_n) !run[1] && inv[1] |=> out_r[1];
   endproperty
   a_off_inverted: assert property (p_off_inverted) else $error("disabled inverted timer not high");

   property p_active_follows;
      @(posedge sys_clk) disable iff (!rst_n) run[0] && !inv[0] |=> out_r[0] == $past(win[0]);
   endproperty
   a_active_follows: assert property (p_active_follows) else $error("running timer output lost window");

   property p_write_answer;
      @(posedge sys_clk) disable iff (!rst_n) do_wr |=> bvalid_r;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write response missing");

   property p_read_answer;
      @(posedge sys_clk) disable iff (!rst_n) s_axi_arvalid && arready_r |=> rvalid_r && !arready_r;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data missing");
endmodule

// file: rtl/cwt_consts.svh
/*
 constants for the calendar window timer: register offsets,
 field positions, write masks and bus response codes.
 assumes a 7-bit AXI4-Lite byte address.
*/
`ifndef CWT_CONSTS_SVH
`define CWT_CONSTS_SVH

`define CWT_ADDR_W        7
`define CWT_TMR_STRIDE    7'h20
`define CWT_OFS_START_DT  3'h0
`define CWT_OFS_START_TM  3'h1
`define CWT_OFS_STOP_DT   3'h2
`define CWT_OFS_STOP_TM   3'h3
`define CWT_OFS_CTRL      3'h4
`define CWT_OFS_DEST      3'h5
`define CWT_OFS_STATUS    3'h6
`define CWT_ADDR_SRC_SEL  7'h40

`define CWT_DT_DAY_LSB    0
`define CWT_DT_MON_LSB    8
`define CWT_DT_YR_LSB     16
`define CWT_TM_SEC_LSB    0
`define CWT_TM_MIN_LSB    8
`define CWT_TM_HR_LSB     16
`define CWT_CTRL_REP_LSB  0
`define CWT_CTRL_EN_BIT   4
`define CWT_CTRL_INV_BIT  5

`define CWT_MASK_DATE     32'h007F_0F1F
`define CWT_MASK_TIME     32'h001F_3F3F
`define CWT_MASK_CTRL     32'h0000_0037
`define CWT_MASK_DEST     32'h0000_FFFF
`define CWT_CFG_RESET     32'h0000_0000

`define CWT_RESP_OKAY     2'h0
`define CWT_RESP_SLVERR   2'h2

`endif

// file: rtl/cwt_pkg.sv
/*
 types shared by the calendar window timer modules.
 assumes nothing beyond a SystemVerilog compiler.
*/
package cwt_pkg;
   typedef enum logic [2:0] {REP_NONE, REP_HOUR, REP_DAY, REP_WEEK,
                             REP_MONTH, REP_YEAR, REP_ONCE, REP_MINUTE} cwt_rep_t;
   typedef struct packed {
      logic [6:0] yr;
      logic [3:0] mo;
      logic [4:0] dy;
      logic [2:0] wd;
      logic [4:0] hr;
      logic [5:0] mi;
      logic [5:0] se;
   } cwt_dt_t;
endpackage

// file: rtl/cwt_tmr_if.sv
/*
 carrier between the register block and one timer core.
 assumes both ends sit in the sys_clk domain.
*/
`timescale 1ns/1ps
interface cwt_tmr_if;
   import cwt_pkg::*;
   logic     tick;
   cwt_dt_t  now;
   cwt_dt_t  start;
   cwt_dt_t  stop;
   cwt_rep_t rep;
   logic     win;
   modport core (input tick, input now, input start, input stop, input rep, output win);
   modport ctl  (output tick, output now, output start, output stop, output rep, input win);
endinterface

// file: rtl/cwt_timer.sv
/*
 one timer core: masks the calendar per repeat period and keeps the
 raw start/stop window, before enable and invert.
 assumes the tick marks each new second of the calendar input.
*/
`timescale 1ns/1ps
module cwt_timer
   import cwt_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   cwt_tmr_if.core   t
);
   cwt_dt_t now_k;
   cwt_dt_t start_k;
   cwt_dt_t stop_k;

   function automatic cwt_dt_t key(input cwt_dt_t v, input cwt_rep_t r);
      cwt_dt_t k;
      k    = '0;
      k.se = v.se;
      if (r != REP_MINUTE)
         k.mi = v.mi;
      if (r inside {REP_DAY, REP_WEEK, REP_MONTH, REP_YEAR, REP_ONCE})
         k.hr = v.hr;
      if (r == REP_WEEK)
         k.wd = v.wd;
      if (r inside {REP_MONTH, REP_YEAR, REP_ONCE})
         k.dy = v.dy;
      if (r inside {REP_YEAR, REP_ONCE})
         k.mo = v.mo;
      if (r == REP_ONCE)
         k.yr = v.yr;
      if (r == REP_NONE)
         k = '0;
      return k;
   endfunction

   assign now_k   = key(t.now, t.rep);
   assign start_k = key(t.start, t.rep);
   assign stop_k  = key(t.stop, t.rep);

   // re-evaluated once per second only
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         t.win <= 1'b0;
      else if (t.tick)
         t.win <= (stop_k > start_k) && (now_k >= start_k) && (now_k < stop_k);
   end

   property p_hold_between_ticks;
      @(posedge sys_clk) disable iff (!rst_n) !t.tick |=> $stable(t.win);
   endproperty
   a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("window moved without tick");

   property p_empty_window;
      @(posedge sys_clk) disable iff (!rst_n) t.tick && (stop_k <= start_k) |=> !t.win;
   endproperty
   a_empty_window: assert property (p_empty_window) else $error("window set with stop at or before start");

   property p_inside_window;
      @(posedge sys_clk) disable iff (!rst_n)
         t.tick && (stop_k > start_k) && (now_k >= start_k) && (now_k < stop_k) |=> t.win;
   endproperty
   a_inside_window: assert property (p_inside_window) else $error("window not set between start and stop");

   property p_minute_mask;
      @(posedge sys_clk) disable iff (!rst_n) t.rep == REP_MINUTE |-> now_k[35:6] == 30'h0000_0000;
   endproperty
   a_minute_mask: assert property (p_minute_mask) else $error("minute period compares more than seconds");
endmodule

// file: verif/cwt_cal_src.sv
/*
 calendar source model: seconds and minutes counting, one-cycle tick
 per new second. assumes sys_clk domain; set loads the calendar whether running or stopped.
*/
`timescale 1ns/1ps
module cwt_cal_src
   import cwt_pkg::*;
#(
   parameter int TICK_CYC = 10
)
(
   input  wire logic    sys_clk,
   input  wire logic    rst_n,
   input  wire logic    run,
   input  wire logic    set,
   input  wire cwt_dt_t set_dt,
   output logic         tick,
   output cwt_dt_t      now
);
   int cnt;
   // carry stops at the hour: short runs never get there
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt  <= 0;
         tick <= 1'b0;
         now  <= '0;
      end
      else
      begin
         tick <= 1'b0;
         if (set)
            now <= set_dt;
         else if (run && cnt == TICK_CYC - 1)
         begin
            cnt    <= 0;
            tick   <= 1'b1;
            now.se <= (now.se == 6'h3B) ? 6'h00 : now.se + 6'h01;
            if (now.se == 6'h3B)
               now.mi <= (now.mi == 6'h3B) ? 6'h00 : now.mi + 6'h01;
         end
         else if (run)
            cnt <= cnt + 1;
      end
   end
endmodule

// file: verif/tb_cwt_top.sv
/*
 self-checking bench for cwt_top: AXI4-Lite tasks, calendar model.
 assumes the package, consts header and design files compile first.
*/
`timescale 1ns/1ps
module tb_cwt_top
   import cwt_pkg::*;
;
   logic        sys_clk, rst_n, awv, wv, bv, brd, arv, rv, rrd;
   logic        awr, wr_r, arr, run, set, tick, drv_reset, trip_log_clr;
   logic [6:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  bresp, rresp, tmr_out;
   cwt_dt_t     now, sdt;
   int          error_cnt, total_checks;

   cwt_top cwt_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rrd), .dt_tick(tick), .dt_sec(now.se), .dt_min(now.mi), .dt_hour(now.hr),
      .dt_day(now.dy), .dt_month(now.mo), .dt_year(now.yr), .dt_wday(now.wd),
      .drv_reset(drv_reset), .tmr_out(tmr_out), .trip_log_clr(trip_log_clr));
   cwt_cal_src cwt_cal_src_inst (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .set(set),
      .set_dt(sdt), .tick(tick), .now(now));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      brd <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awr)
            awv <= 1'b0;
         if (wr_r)
            wv <= 1'b0;
      end
      while (bv !== 1'b1);
      // bready left high: a back-to-back write must not touch it twice in one step
      chk(bresp, er);
   endtask

   task automatic rd(input logic [6:0] a, input logic [31:0] ed, input logic [1:0] er);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arr)
            arv <= 1'b0;
      end
      while (rv !== 1'b1);
      // rready left high, as bready; only the watchdog ends a stuck wait
      chk(rdat, ed);
      chk(rresp, er);
   endtask

   function automatic cwt_dt_t msk(cwt_rep_t r);
      cwt_dt_t m;
      m = '0;
      m.se = '1;
      m.mi = (r != REP_MINUTE) ? 6'h3F : 6'h00;
      m.hr = (r inside {[REP_DAY:REP_ONCE]}) ? 5'h1F : 5'h00;
      m.wd = (r == REP_WEEK) ? 3'h7 : 3'h0;
      m.dy = (r inside {[REP_MONTH:REP_ONCE]}) ? 5'h1F : 5'h00;
      m.mo = (r inside {REP_YEAR, REP_ONCE}) ? 4'hF : 4'h0;
      m.yr = (r == REP_ONCE) ? 7'h7F : 7'h00;
      return m;
   endfunction

   function automatic logic wexp(cwt_rep_t r, logic en, logic inv, cwt_dt_t s, cwt_dt_t p, cwt_dt_t n);
      cwt_dt_t m;
      m = msk(r);
      return (en && r != REP_NONE && (p & m) > (s & m) && (n & m) >= (s & m) && (n & m) < (p & m)) ^ inv;
   endfunction

   // week mode carries the weekday in the low year digits
   function automatic logic [31:0] dtw(cwt_dt_t v, cwt_rep_t r);
      return {9'h000, ((r == REP_WEEK) ? {4'h0, v.wd} : v.yr), 4'h0, v.mo, 3'h0, v.dy};
   endfunction

   function automatic logic [31:0] tmw(cwt_dt_t v);
      return {11'h000, v.hr, 2'h0, v.mi, 2'h0, v.se};
   endfunction

   // programs timer g, loads the calendar, then checks each second after the first
   task automatic run_tmr(input int g, input cwt_rep_t r, input logic en, input logic inv,
                          input cwt_dt_t s, input cwt_dt_t p, input cwt_dt_t n0);
      logic [6:0] b;
      cwt_dt_t    nw;
      int         k;
      b = (g == 1) ? 7'h20 : 7'h00;
      run <= 1'b0;
      wr(b, dtw(s, r), 2'h0);
      wr(b + 7'h04, tmw(s), 2'h0);
      wr(b + 7'h08, dtw(p, r), 2'h0);
      wr(b + 7'h0C, tmw(p), 2'h0);
      wr(b + 7'h10, {26'h000_0000, inv, en, 1'b0, r}, 2'h0);
      set <= 1'b1;
      sdt <= n0;
      @(posedge sys_clk);
      set <= 1'b0;
      run <= 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         k = 0;
         do
         begin
            @(posedge sys_clk);
            k++;
         end
         while (tick !== 1'b1 && k < 100);
         nw = now;
         repeat (3) @(posedge sys_clk);
         if (i > 0)
            chk(tmr_out[g], wexp(r, en, inv, s, p, nw));
      end
      rd(b + 7'h18, {31'h0000_0000, wexp(r, en, inv, s, p, nw)}, 2'h0);
   endtask

   task automatic t_modes();
      cwt_dt_t s, p, a;
      s = '{yr:7'h19, mo:4'h6, dy:5'h0F, wd:3'h1, hr:5'h0A, mi:6'h14, se:6'h0A};
      a = '{yr:7'h28, mo:4'h3, dy:5'h04, wd:3'h5, hr:5'h02, mi:6'h07, se:6'h07};
      p = s;
      p.se = 6'h0D;
      for (int r = 0; r < 8; r++)
         run_tmr(0, cwt_rep_t'(r), 1'b1, 1'b0, s, p, (s & msk(cwt_rep_t'(r))) | (a & ~msk(cwt_rep_t'(r))));
      run_tmr(1, REP_HOUR, 1'b1, 1'b1, s, p, a);
      run_tmr(1, REP_MINUTE, 1'b1, 1'b0, s, s, a);
      run_tmr(0, REP_MINUTE, 1'b0, 1'b1, s, p, a);
      run_tmr(0, REP_NONE, 1'b1, 1'b0, s, p, a);
   endtask

   task automatic t_regs();
      rd(7'h10, 32'h0000_0000, 2'h0);
      chk(tmr_out, 2'h0);
      wr(7'h14, 32'h0000_BEEF, 2'h0);
      rd(7'h14, 32'h0000_BEEF, 2'h0);
      wr(7'h1C, 32'h0000_0001, 2'h2);
      rd(7'h1C, 32'h0000_0000, 2'h2);
   endtask

   task automatic pulse(input logic exp);
      drv_reset <= 1'b1;
      @(posedge sys_clk);
      drv_reset <= 1'b0;
      #1;
      chk(trip_log_clr, exp);
      @(posedge sys_clk);
      #1;
      chk(trip_log_clr, 1'b0);
      @(posedge sys_clk);
   endtask

   task automatic t_src();
      wr(7'h10, 32'h0000_0012, 2'h0);
      wr(7'h30, 32'h0000_0017, 2'h0);
      wr(7'h40, 32'h0000_0001, 2'h0);
      pulse(1'b1);
      rd(7'h10, 32'h0000_0010, 2'h0);
      rd(7'h30, 32'h0000_0010, 2'h0);
      rd(7'h40, 32'h0000_0003, 2'h0);
      pulse(1'b0);
   endtask

   initial
   begin
      {rst_n, awv, wv, brd, arv, rrd, run, set, drv_reset} = '0;
      {awa, ara, wd} = '0;
      sdt = '0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_modes();
      t_src();
      results();
   end

   // whole run is about 1,300 cycles; this leaves wide margin
   initial
   begin
      #(20000 * 8);
      error_cnt++;
      results();
   end
endmodule
